//--- rtl/tdp_regs.svh
// Register offsets, field positions, reset values and timing counts of the pulse timer.
`ifndef TDP_REGS_SVH
`define TDP_REGS_SVH

`define TDP_OFF_CTRL    8'h00
`define TDP_OFF_DELAY   8'h04
`define TDP_OFF_LENGTH  8'h08
`define TDP_OFF_RESTART 8'h0c
`define TDP_OFF_COUNT   8'h10
`define TDP_OFF_STATE   8'h14

`define TDP_SRC_LSB     0
`define TDP_SRC_MSB     1
`define TDP_COND_LSB    4
`define TDP_COND_MSB    6
`define TDP_LINE_LSB    8
`define TDP_LINE_MSB    9
`define TDP_SEL_BIT     12
`define TDP_RESTART_BIT 0

`define TDP_CTRL_RST    32'h0000_0000
`define TDP_DELAY_RST   26'h000_0000
`define TDP_LENGTH_RST  26'h000_0001
`define TDP_MAX_US      26'd60000000

`define TDP_ST_IDLE     2'h0
`define TDP_ST_WAIT     2'h1
`define TDP_ST_ACTIVE   2'h2

`define TDP_CLK_NS      20
`define TDP_TICK_NS     1000
`define TDP_TICK_CYC    ((`TDP_TICK_NS + `TDP_CLK_NS - 1) / `TDP_CLK_NS)

`endif

//--- rtl/tdp_pkg.sv
// Types shared by the pulse timer: sources, conditions, line routing and control layout.
package tdp_pkg;
    typedef enum logic [1:0] {SRC_OFF, SRC_EXPOSURE, SRC_READOUT, SRC_EXT0} tdp_src_e;
    typedef enum logic [2:0] {TRIG_ON_RISE, TRIG_ON_FALL, TRIG_ON_EITHER,
                              GATE_WHILE_HIGH, GATE_WHILE_LOW} tdp_cond_e;
    typedef enum logic [1:0] {LINE_OFF, LINE_EXPOSURE, LINE_READOUT, LINE_PULSE} tdp_line_e;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_RUN} tdp_state_e;
    typedef struct packed {
        tdp_line_e outputLineSource;
        tdp_cond_e triggerCondition;
        tdp_src_e  triggerSource;
    } tdp_ctrl_s;
endpackage

//--- rtl/tdp_pulse_timer.sv
// Triggered delay-and-pulse timer with an AHB-Lite register slave and output line routing.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "tdp_regs.svh"

module tdp_pulse_timer #(
    parameter int CNT_W = 26
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Camera acquisition signals.
    input  wire logic        exposureWindow,
    input  wire logic        readoutWindow,
    input  wire logic        extInputZero,
    // Outputs.
    output logic             pulseUnitZeroOutput,
    output logic             outputLine
);
    localparam logic [5:0] TICK_LAST = 6'(`TDP_TICK_CYC - 1);
    localparam logic [31:0] CTRL_RST_W = `TDP_CTRL_RST;
    localparam tdp_pkg::tdp_ctrl_s CTRL_RST_S = '{
        outputLineSource: tdp_pkg::tdp_line_e'(CTRL_RST_W[`TDP_LINE_MSB:`TDP_LINE_LSB]),
        triggerCondition: tdp_pkg::tdp_cond_e'(CTRL_RST_W[`TDP_COND_MSB:`TDP_COND_LSB]),
        triggerSource:    tdp_pkg::tdp_src_e'(CTRL_RST_W[`TDP_SRC_MSB:`TDP_SRC_LSB])
    };

    tdp_pkg::tdp_ctrl_s  ctrl_q;
    tdp_pkg::tdp_state_e state_q;
    tdp_pkg::tdp_state_e state_d;
    logic [CNT_W-1:0]    delay_q;
    logic [CNT_W-1:0]    length_q;
    logic [CNT_W-1:0]    count_q;
    logic [5:0]          tick_q;
    logic                restart_q;
    logic                wrPend_q;
    logic [7:0]          wrAddr_q;
    logic                out_q;
    logic                line_q;
    logic [31:0]         rdata_q;
    logic                srcPrev_q;
    logic                srcLvl;
    logic                fire;
    logic                gateOk;
    logic                edgeMode;
    logic                tickWrap;
    logic                clrAll;
    logic                delayDone;
    logic                runDone;
    logic                addrPhase;
    logic [1:0]          stateCode;

    function automatic logic isEdge(input tdp_pkg::tdp_cond_e c);
        return c == tdp_pkg::TRIG_ON_RISE || c == tdp_pkg::TRIG_ON_FALL ||
               c == tdp_pkg::TRIG_ON_EITHER;
    endfunction

    function automatic logic [CNT_W-1:0] clampUs(input logic [31:0] v, input logic minOne);
        logic [CNT_W-1:0] r;
        r = CNT_W'(v);
        if (v > 32'(`TDP_MAX_US)) begin
            r = CNT_W'(`TDP_MAX_US);
        end else if (minOne && v == 32'h0) begin
            r = CNT_W'(1);
        end
        return r;
    endfunction

    function automatic logic [1:0] reportState(input tdp_pkg::tdp_state_e s);
        case (s)
            tdp_pkg::ST_IDLE: return `TDP_ST_IDLE;
            tdp_pkg::ST_WAIT: return `TDP_ST_WAIT;
            default:          return `TDP_ST_ACTIVE;
        endcase
    endfunction

    // Read-back puts each field at its write position, so software sees what it wrote.
    function automatic logic [31:0] packCtrl(input tdp_pkg::tdp_ctrl_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`TDP_SRC_MSB:`TDP_SRC_LSB]   = c.triggerSource;
        w[`TDP_COND_MSB:`TDP_COND_LSB] = c.triggerCondition;
        w[`TDP_LINE_MSB:`TDP_LINE_LSB] = c.outputLineSource;
        return w;
    endfunction

    // The slave never stalls and never errors.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign addrPhase = hsel && htrans[1] && hready;
    assign stateCode = reportState(state_q);

    // Write data arrives one cycle after the address, so the address is held here.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else begin
            wrPend_q <= addrPhase && hwrite;
            wrAddr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= CTRL_RST_S;
            delay_q  <= `TDP_DELAY_RST;
            length_q <= `TDP_LENGTH_RST;
        end else if (wrPend_q) begin
            case (wrAddr_q)
                `TDP_OFF_CTRL: begin
                    // Only unit zero exists, so a write naming another unit is dropped.
                    if (!hwdata[`TDP_SEL_BIT]) begin
                        ctrl_q.triggerSource    <=
                            tdp_pkg::tdp_src_e'(hwdata[`TDP_SRC_MSB:`TDP_SRC_LSB]);
                        ctrl_q.triggerCondition <=
                            tdp_pkg::tdp_cond_e'(hwdata[`TDP_COND_MSB:`TDP_COND_LSB]);
                        ctrl_q.outputLineSource <=
                            tdp_pkg::tdp_line_e'(hwdata[`TDP_LINE_MSB:`TDP_LINE_LSB]);
                    end
                end
                `TDP_OFF_DELAY:  delay_q  <= clampUs(hwdata, 1'b0);
                `TDP_OFF_LENGTH: length_q <= clampUs(hwdata, 1'b1);
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= wrPend_q && wrAddr_q == `TDP_OFF_RESTART &&
                         hwdata[`TDP_RESTART_BIT];
        end
    end

    // Read data is latched in the address phase and stands through the data phase.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            case (haddr[7:0])
                `TDP_OFF_CTRL:   rdata_q <= packCtrl(ctrl_q);
                `TDP_OFF_DELAY:  rdata_q <= 32'(delay_q);
                `TDP_OFF_LENGTH: rdata_q <= 32'(length_q);
                `TDP_OFF_COUNT:  rdata_q <= 32'(count_q);
                `TDP_OFF_STATE:  rdata_q <= 32'(stateCode);
                default:         rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Exposure window is taken as given by the sensor timing, high for the exposure.
    always_comb begin
        case (ctrl_q.triggerSource)
            tdp_pkg::SRC_EXPOSURE: srcLvl = exposureWindow;
            tdp_pkg::SRC_READOUT:  srcLvl = readoutWindow;
            tdp_pkg::SRC_EXT0:     srcLvl = extInputZero;
            default:               srcLvl = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            srcPrev_q <= 1'b0;
        end else begin
            srcPrev_q <= srcLvl;
        end
    end

    assign edgeMode = isEdge(ctrl_q.triggerCondition);

    always_comb begin
        gateOk = 1'b0;
        fire   = 1'b0;
        case (ctrl_q.triggerCondition)
            tdp_pkg::TRIG_ON_RISE:    fire = srcLvl && !srcPrev_q;
            tdp_pkg::TRIG_ON_FALL:    fire = !srcLvl && srcPrev_q;
            tdp_pkg::TRIG_ON_EITHER:  fire = srcLvl != srcPrev_q;
            tdp_pkg::GATE_WHILE_HIGH: gateOk = srcLvl;
            tdp_pkg::GATE_WHILE_LOW:  gateOk = !srcLvl;
            default: ;
        endcase
        if (!edgeMode) begin
            fire = gateOk;
        end
    end

    assign clrAll    = restart_q || ctrl_q.triggerSource == tdp_pkg::SRC_OFF;
    assign tickWrap  = tick_q == TICK_LAST;
    assign delayDone = tickWrap && count_q + CNT_W'(1) >= delay_q;
    assign runDone   = tickWrap && count_q + CNT_W'(1) >= length_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            tdp_pkg::ST_IDLE: state_d = tdp_pkg::ST_WAIT;
            tdp_pkg::ST_WAIT: begin
                if (fire) begin
                    state_d = delay_q == '0 ? tdp_pkg::ST_RUN : tdp_pkg::ST_DELAY;
                end
            end
            tdp_pkg::ST_DELAY: begin
                if (!edgeMode && !gateOk) begin
                    state_d = tdp_pkg::ST_WAIT;
                end else if (delayDone) begin
                    state_d = tdp_pkg::ST_RUN;
                end
            end
            tdp_pkg::ST_RUN: begin
                if (edgeMode ? runDone : !gateOk) begin
                    state_d = tdp_pkg::ST_WAIT;
                end
            end
            default: state_d = tdp_pkg::ST_IDLE;
        endcase
        if (clrAll) begin
            state_d = tdp_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= tdp_pkg::ST_IDLE;
            out_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            out_q   <= state_d == tdp_pkg::ST_RUN;
        end
    end

    // The tick restarts on every state change so each phase lasts whole microseconds.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 6'h00;
        end else if (state_d != state_q || tickWrap || clrAll) begin
            tick_q <= 6'h00;
        end else begin
            tick_q <= tick_q + 6'h01;
        end
    end

    // In gate mode the count keeps running while the source holds and simply wraps.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (state_d != state_q || clrAll) begin
            count_q <= '0;
        end else if (tickWrap && state_q inside {tdp_pkg::ST_DELAY, tdp_pkg::ST_RUN}) begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= 1'b0;
        end else begin
            case (ctrl_q.outputLineSource)
                tdp_pkg::LINE_EXPOSURE: line_q <= exposureWindow;
                tdp_pkg::LINE_READOUT:  line_q <= readoutWindow;
                tdp_pkg::LINE_PULSE:    line_q <= out_q;
                default:                line_q <= 1'b0;
            endcase
        end
    end

    assign pulseUnitZeroOutput = out_q;
    assign outputLine          = line_q;

    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [31:0] runCyc_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            runCyc_q <= 32'h0;
        end else begin
            runCyc_q <= out_q ? runCyc_q + 32'h1 : 32'h0;
        end
    end

    sequence seqLinePicked;
        ctrl_q.outputLineSource == tdp_pkg::LINE_PULSE;
    endsequence
    sequence seqTickGap;
        !tickWrap [*8];
    endsequence

    chk_line_route: assert property (seqLinePicked |=> line_q == $past(out_q))
        else $error("output line does not follow timer output");
    chk_off_idle: assert property (ctrl_q.triggerSource == tdp_pkg::SRC_OFF
        |=> stateCode == `TDP_ST_IDLE && !out_q)
        else $error("timer left idle while source is off");
    chk_edge_length: assert property (out_q && edgeMode && !clrAll
        |-> runCyc_q < 32'(length_q) * 32'(`TDP_TICK_CYC))
        else $error("edge pulse longer than programmed length");
    chk_delay_bound: assert property (state_q == tdp_pkg::ST_DELAY
        |-> !out_q && count_q < delay_q)
        else $error("delay overran or output high during delay");
    chk_restart_clear: assert property (restart_q |=> count_q == '0 && !out_q)
        else $error("restart did not clear the timer");
    chk_count_idle: assert property (stateCode != `TDP_ST_ACTIVE |-> count_q == '0)
        else $error("count not zero while idle or waiting");
    chk_state_legal: assert property (stateCode inside {`TDP_ST_IDLE, `TDP_ST_WAIT,
        `TDP_ST_ACTIVE} && (!out_q || stateCode == `TDP_ST_ACTIVE))
        else $error("illegal reported state");
    chk_rise_only: assert property (state_q == tdp_pkg::ST_WAIT && !clrAll &&
        ctrl_q.triggerCondition == tdp_pkg::TRIG_ON_RISE && !(srcLvl && !srcPrev_q)
        |=> state_q == tdp_pkg::ST_WAIT)
        else $error("timer fired without a rising edge");
    chk_fall_only: assert property (state_q == tdp_pkg::ST_WAIT && !clrAll &&
        ctrl_q.triggerCondition == tdp_pkg::TRIG_ON_FALL && !(!srcLvl && srcPrev_q)
        |=> state_q == tdp_pkg::ST_WAIT)
        else $error("timer fired without a falling edge");
    chk_gate_high: assert property (!srcLvl &&
        ctrl_q.triggerCondition == tdp_pkg::GATE_WHILE_HIGH |=> !out_q)
        else $error("output high while source low in gate-high mode");
    chk_gate_low: assert property (srcLvl &&
        ctrl_q.triggerCondition == tdp_pkg::GATE_WHILE_LOW |=> !out_q)
        else $error("output high while source high in gate-low mode");
    chk_tick_period: assert property (tickWrap && !clrAll |=> seqTickGap)
        else $error("microsecond tick came too early");
endmodule

//--- test/tdp_cam_model.sv
// Camera acquisition model driving the exposure, readout and external input levels.
`timescale 1ns/100ps

module tdp_cam_model (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst_n,
    // Acquisition levels.
    output logic      exposureWindow,
    output logic      readoutWindow,
    output logic      extInputZero
);
    initial begin
        exposureWindow = 1'b0;
        readoutWindow  = 1'b0;
        extInputZero   = 1'b0;
    end

    // Levels move just after a rising edge so the timer never samples them mid-change.
    task automatic setLines(input logic [2:0] v);
        @(posedge mclk);
        exposureWindow <= v[2];
        readoutWindow  <= v[1];
        extInputZero   <= v[0];
    endtask
endmodule

//--- test/tdp_pulse_timer_tb.sv
// Self-checking bench for the triggered pulse timer.
`timescale 1ns/100ps
`include "tdp_regs.svh"

module tdp_pulse_timer_tb;
    logic        mclk   = 1'b0;
    logic        rst_n  = 1'b0;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize  = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        pulseOut;
    logic        outputLine;
    logic        expW;
    logic        rdW;
    logic        ext0;
    logic [31:0] rd;
    logic        cur;
    int          n;
    int          nMismatch = 0;
    int          nTests    = 0;

    always #10 mclk = ~mclk;

    tdp_pulse_timer DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .exposureWindow(expW), .readoutWindow(rdW), .extInputZero(ext0),
        .pulseUnitZeroOutput(pulseOut), .outputLine(outputLine));

    tdp_cam_model cam (.mclk(mclk), .rst_n(rst_n), .exposureWindow(expW),
        .readoutWindow(rdW), .extInputZero(ext0));

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic checkIn(input int v, input int lo, input int hi);
        check(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge mclk);
    endtask

    // A wait that runs out of its bound counts as a mismatch and ends the run.
    task automatic waitReady;
        int k;
        k = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1) begin
            if (++k > 100) begin
                nMismatch++;
                summarize();
            end
            @(posedge mclk);
        end
    endtask

    task automatic waitOut(input logic lv, input int lim, output int cnt);
        cnt = 0;
        while (pulseOut !== lv) begin
            if (++cnt > lim) begin
                nMismatch++;
                summarize();
            end
            @(posedge mclk);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        waitReady();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    function automatic logic [31:0] ctrl(input int s, input int c, input int l);
        return 32'((l << 8) | (c << 4) | s);
    endfunction

    task automatic s_regs;
        rdChk(`TDP_OFF_CTRL, `TDP_CTRL_RST);
        check(hresp, 1'b0);
        check(hreadyout, 1'b1);
        rdChk(`TDP_OFF_DELAY, `TDP_DELAY_RST);
        rdChk(`TDP_OFF_LENGTH, `TDP_LENGTH_RST);
        rdChk(`TDP_OFF_STATE, `TDP_ST_IDLE);
        rdChk(`TDP_OFF_COUNT, 32'h0);
        rdChk(8'h20, 32'h0);
        wr(`TDP_OFF_LENGTH, 32'h0);
        rdChk(`TDP_OFF_LENGTH, 32'h1);
        wr(`TDP_OFF_DELAY, 32'h0393_8701);
        rdChk(`TDP_OFF_DELAY, 32'h0393_8700);
        wr(`TDP_OFF_CTRL, 32'h0000_1000 | ctrl(3, 0, 3));
        rdChk(`TDP_OFF_CTRL, 32'h0);
        wr(`TDP_OFF_RESTART, 32'h1);
        rdChk(`TDP_OFF_RESTART, 32'h0);
    endtask

    task automatic s_off;
        wr(`TDP_OFF_CTRL, ctrl(0, 2, 3));
        cam.setLines(3'b111);
        cycles(5);
        cam.setLines(3'b000);
        cycles(5);
        rdChk(`TDP_OFF_STATE, `TDP_ST_IDLE);
        check(pulseOut, 1'b0);
    endtask

    task automatic firePulse;
        cur = !cur;
        cam.setLines({2'b00, cur});
        waitOut(1'b1, 300, n);
        checkIn(n, 50, 53);
        waitOut(1'b0, 300, n);
        checkIn(n, 49, 51);
        check(outputLine, 1'b1);
        @(posedge mclk);
        check(outputLine, 1'b0);
    endtask

    // The rise and fall modes first see the opposite edge, which must not fire; the either-edge mode fires on both edges.
    task automatic s_edge;
        wr(`TDP_OFF_DELAY, 32'h1);
        wr(`TDP_OFF_LENGTH, 32'h1);
        for (int c = 0; c < 3; c++) begin
            cur = (c == 0);
            cam.setLines({2'b00, cur});
            wr(`TDP_OFF_CTRL, ctrl(3, c, 3));
            rdChk(`TDP_OFF_CTRL, ctrl(3, c, 3));
            cycles(3);
            rdChk(`TDP_OFF_STATE, `TDP_ST_WAIT);
            if (c != 2) begin
                cur = !cur;
                cam.setLines({2'b00, cur});
                cycles(60);
                check(pulseOut, 1'b0);
            end
            firePulse();
            if (c == 2) begin
                firePulse();
            end
        end
    endtask

    task automatic s_gate;
        wr(`TDP_OFF_DELAY, 32'h0);
        for (int g = 0; g < 2; g++) begin
            logic [2:0] m;
            m = g ? 3'b100 : 3'b010;
            cam.setLines(g ? m : 3'b000);
            wr(`TDP_OFF_CTRL, ctrl(g ? 1 : 2, g ? 4 : 3, 3));
            cycles(10);
            check(pulseOut, 1'b0);
            cam.setLines(g ? 3'b000 : m);
            waitOut(1'b1, 10, n);
            cycles(30);
            check(pulseOut, 1'b1);
            cam.setLines(g ? m : 3'b000);
            waitOut(1'b0, 3, n);
            checkIn(n, 1, 3);
        end
    endtask

    task automatic s_restart;
        wr(`TDP_OFF_CTRL, ctrl(3, 0, 3));
        wr(`TDP_OFF_DELAY, 32'd100);
        cam.setLines(3'b000);
        cycles(3);
        cam.setLines(3'b001);
        cycles(200);
        rdChk(`TDP_OFF_STATE, `TDP_ST_ACTIVE);
        ahb(1'b0, `TDP_OFF_COUNT, 32'h0);
        checkIn(int'(rd), 3, 5);
        wr(`TDP_OFF_RESTART, 32'h1);
        cycles(2);
        rdChk(`TDP_OFF_STATE, `TDP_ST_WAIT);
        rdChk(`TDP_OFF_COUNT, 32'h0);
        check(pulseOut, 1'b0);
    endtask

    // The line follows the window inputs one cycle late; the timer is kept off meanwhile.
    task automatic s_line;
        for (int l = 0; l < 3; l++) begin
            wr(`TDP_OFF_CTRL, ctrl(0, 0, l));
            cam.setLines(3'b111);
            cycles(2);
            check(outputLine, l != 0);
            cam.setLines(3'b000);
            cycles(2);
            check(outputLine, 1'b0);
        end
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        s_regs();
        s_off();
        s_edge();
        s_gate();
        s_restart();
        s_line();
        summarize();
    end
endmodule
